// *** test/branch_source_model.sv ***
// Far-side model: retirement logic presenting qualified branches to the recorder
module branch_source_model
  import trace_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          fire,
  input  wire branch_event_t ev_in,
  input  wire logic          legacy_in,
  output branch_event_t      branch_out,
  output logic               legacy_mode_flag
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Strobe and mode level
  // ----------------------------------------------------------------
  branch_event_t scrambled;

  always_comb begin
    scrambled       = ~branch_out;
    scrambled.valid = 1'b0;
  end

  always_ff @(posedge clk) begin
    legacy_mode_flag <= legacy_in;
    if (reset) begin
      branch_out <= '0;
    end else if (fire) begin
      branch_out <= ev_in;
    end else begin
      // Payload is meaningless off the strobe, so it keeps moving
      branch_out <= scrambled;
    end
  end
endmodule

// *** test/tb.sv ***
// Self-checking bench for the branch trace recorder
module tb
  import trace_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          clk, reset, fire, leg, legacy_w, hlt, exp_w;
  logic          awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic          halted, oi, evis, supp;
  logic [7:0]    awaddr, araddr, known;
  logic [31:0]   wdata, rdata, seed, lo, hi, q;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp, resp;
  logic [2:0]    exp_p;
  logic [63:0]   exp_e [8];
  branch_event_t ev_q, b_in;
  int            n_mismatch, n_checks;

  branch_source_model u_src (.clk(clk), .reset(reset), .fire(fire), .ev_in(ev_q), .legacy_in(leg),
    .branch_out(b_in), .legacy_mode_flag(legacy_w));
  branch_trace_recorder DUT (.clk(clk), .reset(reset), .branch_in(b_in), .legacy_mode_flag(legacy_w),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .collection_halted(halted), .overflow_irq_enable(oi),
    .external_visibility(evis), .interrupt_vector_suppress(supp));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [63:0] mk(input logic [59:0] a, input logic [1:0] s, input logic m, input logic k);
    logic [63:0] e;
    e = {a, s, m, k};
    e[60:51] = {10{e[50]}};
    return e;
  endfunction

  function automatic void put(input logic [63:0] v);
    exp_e[exp_p] = v;
    known[exp_p] = 1'b1;
    exp_p = exp_p + 3'h1;
    if (exp_p == 3'h0) exp_w = 1'b1;
  endfunction

  // One AXI4-Lite transfer; write when wr is set, read otherwise
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    logic ta, tw, tr, got;
    int   i;
    @(posedge clk);
    awaddr  <= a;
    araddr  <= a;
    wdata   <= d;
    awvalid <= wr;
    wvalid  <= wr;
    bready  <= wr;
    arvalid <= !wr;
    rready  <= !wr;
    got = 1'b0;
    for (i = 0; i < 64 && !got; i++) begin
      // Sampled mid-cycle: nothing moves again before the next rising edge
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = arvalid && arready;
      got = (bvalid && bready) || (rvalid && rready);
      resp = wr ? bresp : rresp;
      r = rdata;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      if (got) bready <= 1'b0;
      if (got) rready <= 1'b0;
    end
    if (!got) begin
      n_mismatch++;
      $display("ERROR %0t bus handshake timeout", $time);
      complete_run();
    end
  endtask

  task automatic send(input logic legacy);
    branch_event_t e;
    logic [63:0]   t;
    t = {rnd(), rnd()};
    e.src_addr = t[59:0];
    t = {rnd(), rnd()};
    e.tgt_addr = t[59:0];
    t = {32'h0, rnd()};
    e.valid = t[2:0] != 3'h0;
    e.slot = 2'(t[7:4] % 4'h3);
    e.taken = t[8];
    e.mispredict = t[9];
    e.record_target = t[10] | t[11];
    e.merge_source = t[12] & t[13];
    @(posedge clk);
    fire <= 1'b1;
    ev_q <= e;
    leg  <= legacy;
    if (e.valid && !legacy && !hlt) begin
      put(mk(e.src_addr, e.taken ? e.slot : SLOT_NOT_TAKEN, e.mispredict, 1'b1));
      if (e.record_target && !e.merge_source) put(mk(e.tgt_addr, SLOT_TARGET, 1'b1, 1'b0));
    end
  endtask

  task automatic idle();
    @(posedge clk);
    fire <= 1'b0;
    leg  <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic check_all();
    int last;
    for (int n = 0; n < 8; n++) begin
      bus(1'b0, 8'(8 * n), 32'h0, lo);
      bus(1'b0, 8'(8 * n + 4), 32'h0, hi);
      if (known[n]) chk({hi, lo}, exp_e[n]);
    end
    bus(1'b0, INDEX_OFF, 32'h0, q);
    chk(64'(q[3:0]), 64'({exp_w, exp_p}));
    chk(64'(resp), 64'(RESP_OKAY));
    last = 8 + ((8 * int'(q[3]) + int'(q[2:0]) - 1) % 8);
    if (exp_w || exp_p != 3'h0) chk(64'(last), 64'(8 + int'(3'(exp_p - 3'h1))));
  endtask

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    {reset, fire, leg, awvalid, wvalid, bready, arvalid, rready} = 8'hFF & 8'h80;
    {awaddr, araddr, wdata, ev_q} = '0;
    wstrb = 4'hF;
    seed = 32'hCE2862FB;
    {known, exp_p, exp_w, hlt} = 13'h1;
    n_mismatch = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    bus(1'b0, CONFIG_OFF, 32'h0, q);
    chk(64'(q[3:0]), 64'h9);
    chk(64'({supp, evis, oi, halted}), 64'h9);
    bus(1'b0, 8'h80, 32'h0, q);
    chk(64'({resp, q}), 64'({RESP_SLVERR, 32'h0}));
    bus(1'b1, 8'h48, 32'hFFFFFFFF, q);
    chk(64'(resp), 64'(RESP_SLVERR));
    bus(1'b1, INDEX_OFF, 32'hB, q);
    bus(1'b0, INDEX_OFF, 32'h0, q);
    chk(64'(q[3:0]), 64'hB);
    // Start one short of the end so the first capture wraps at once
    bus(1'b1, INDEX_OFF, 32'h7, q);
    exp_p = 3'h7;
    for (int r = 0; r < 6; r++) begin
      if (r == 3) begin
        bus(1'b1, INDEX_OFF, 32'h0, q);
        exp_p = 3'h0;
        exp_w = 1'b0;
      end
      bus(1'b1, CONFIG_OFF, r[0] ? 32'h6 : 32'h8, q);
      hlt = 1'b0;
      chk(64'({supp, evis, oi, halted}), r[0] ? 64'h6 : 64'h8);
      repeat (4 + r) send(r == 1 && seed[5]);
      idle();
      bus(1'b1, CONFIG_OFF, 32'h9, q);
      hlt = 1'b1;
      chk(64'({supp, evis, oi, halted}), 64'h9);
      send(1'b0);
      idle();
      check_all();
    end
    // Software store of the extension bits keeps what was written
    bus(1'b1, 8'h2C, 32'h1AA80000, q);
    bus(1'b1, 8'h28, 32'h12345678, q);
    // Only byte 1 of the low word may change
    wstrb <= 4'h2;
    bus(1'b1, 8'h28, 32'hAABBCCDD, q);
    wstrb <= 4'hF;
    exp_e[5] = {32'h1AA80000, 32'h1234CC78};
    known[5] = 1'b1;
    check_all();
    complete_run();
  end
endmodule

// *** verilog/branch_trace_recorder.sv ***
// Branch trace recorder: eight-entry circular trace with AXI4-Lite register access
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
module branch_trace_recorder
  import trace_pkg::*;
#(
  parameter int ENTRY_COUNT = ENTRIES
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire branch_event_t branch_in,
  input  wire logic          legacy_mode_flag,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               collection_halted,
  output logic               overflow_irq_enable,
  output logic               external_visibility,
  output logic               interrupt_vector_suppress
);

  // Storage and pointer width are fixed to eight entries
  if (ENTRY_COUNT != ENTRIES) begin : g_bad_count
    $error("ENTRY_COUNT must equal 8");
  end

  logic [63:0]      entry_reg [ENTRIES];
  logic [PTR_W-1:0] ptr_reg;
  logic             wrap_reg;

  // ----------------------------------------------------------------
  // Capture qualification
  // ----------------------------------------------------------------
  // Filter already qualified; legacy execution and halt gate it here
  logic capture;
  logic two_entries;
  assign capture     = branch_in.valid && !legacy_mode_flag && !collection_halted;
  assign two_entries = branch_in.record_target && !branch_in.merge_source;

  function automatic logic [63:0] make_entry(input logic [59:0] addr, input logic [1:0] slot,
                                              input logic mp, input logic kind);
    logic [59:0] a;
    a = addr;
    a[SEXT_HI-ADDR_LO:SEXT_LO-ADDR_LO] = {10{addr[SEXT_SRC-ADDR_LO]}};
    make_entry = {a, slot, mp, kind};
  endfunction

  logic [63:0] src_entry;
  logic [63:0] tgt_entry;
  logic [1:0]  src_slot;
  assign src_slot  = branch_in.taken ? branch_in.slot : SLOT_NOT_TAKEN;
  assign src_entry = make_entry(branch_in.src_addr, src_slot, branch_in.mispredict, 1'b1);
  assign tgt_entry = make_entry(branch_in.tgt_addr, SLOT_TARGET, 1'b1, 1'b0);

  logic [PTR_W-1:0] ptr_plus1;
  logic [PTR_W-1:0] ptr_plus2;
  logic             wraps;
  assign ptr_plus1 = ptr_reg + 3'h1;
  assign ptr_plus2 = ptr_reg + 3'h2;
  assign wraps     = capture && ((ptr_reg == 3'h7) || (two_entries && ptr_reg == 3'h6));

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        do_write;

  assign do_write = aw_held && w_held;

  // Readies are registered: one idle cycle after each response
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
    end else if (!aw_held && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
    end else if (!w_held && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held     <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held     <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  logic wr_entry;
  logic wr_index;
  logic wr_config;
  logic [2:0] wr_idx;
  assign wr_idx    = aw_addr_reg[5:3];
  assign wr_entry  = do_write && aw_addr_reg[7:6] == 2'h0 && aw_addr_reg[1:0] == 2'h0;
  assign wr_index  = do_write && aw_addr_reg == INDEX_OFF;
  assign wr_config = do_write && aw_addr_reg == CONFIG_OFF;

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_entry || wr_index || wr_config) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    merge = r;
  endfunction

  // ----------------------------------------------------------------
  // Trace storage
  // ----------------------------------------------------------------
  // Capture beats a software write to the same slot: trace is live data
  generate
    for (genvar e = 0; e < ENTRIES; e++) begin : g_entry
      always_ff @(posedge clk) begin
        if (capture && ptr_reg == PTR_W'(e)) begin
          entry_reg[e] <= src_entry;
        end else if (capture && two_entries && ptr_plus1 == PTR_W'(e)) begin
          entry_reg[e] <= tgt_entry;
        end else if (wr_entry && wr_idx == PTR_W'(e)) begin
          if (aw_addr_reg[2]) begin
            entry_reg[e][63:32] <= merge(entry_reg[e][63:32], w_data_reg, w_strb_reg);
          end else begin
            entry_reg[e][31:0] <= merge(entry_reg[e][31:0], w_data_reg, w_strb_reg);
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Index register
  // ----------------------------------------------------------------
  // Entries and index come up undefined to software; only the index is zeroed for determinism, entries are not reset
  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_reg  <= 3'h0;
      wrap_reg <= 1'b0;
    end else begin
      if (wr_index && w_strb_reg[0]) begin
        ptr_reg  <= w_data_reg[PTR_W-1:0];
        wrap_reg <= w_data_reg[WRAP_BIT];
      end
      if (capture) begin
        ptr_reg <= two_entries ? ptr_plus2 : ptr_plus1;
      end
      if (wraps) begin
        wrap_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Monitor configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      collection_halted         <= CFG_HALT_RST;
      overflow_irq_enable       <= CFG_OI_RST;
      external_visibility       <= CFG_EV_RST;
      interrupt_vector_suppress <= CFG_SUPP_RST;
    end else if (wr_config && w_strb_reg[0]) begin
      collection_halted         <= w_data_reg[CFG_HALT_BIT];
      overflow_irq_enable       <= w_data_reg[CFG_OI_BIT];
      external_visibility       <= w_data_reg[CFG_EV_BIT];
      interrupt_vector_suppress <= w_data_reg[CFG_SUPP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [7:0]  ra;
  logic [31:0] rd;
  logic        rok;
  assign ra = s_axi_araddr;

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_comb begin
    rd  = 32'h0000_0000;
    rok = 1'b1;
    if (ra[7:6] == 2'h0 && ra[1:0] == 2'h0) begin
      // Live reads are allowed but meaningless unless halted
      rd = ra[2] ? entry_reg[ra[5:3]][63:32] : entry_reg[ra[5:3]][31:0];
    end else if (ra == INDEX_OFF) begin
      rd = {28'h0000000, wrap_reg, ptr_reg};
    end else if (ra == CONFIG_OFF) begin
      rd = {28'h0000000, interrupt_vector_suppress, external_visibility, overflow_irq_enable, collection_halted};
    end else begin
      rok = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd;
      s_axi_rresp  <= rok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_capture_two;
    capture && two_entries;
  endsequence

  property p_no_capture_halted;
    @(posedge clk) disable iff (reset) (collection_halted && !wr_index) |=> $stable(ptr_reg);
  endproperty
  a_no_capture_halted: assert property (p_no_capture_halted) else $error("pointer moved while halted");

  property p_legacy_silent;
    @(posedge clk) disable iff (reset) (legacy_mode_flag && !wr_index) |=> $stable(ptr_reg);
  endproperty
  a_legacy_silent: assert property (p_legacy_silent) else $error("capture during legacy mode");

  property p_step_one;
    @(posedge clk) disable iff (reset) (capture && !two_entries) |=> ptr_reg == $past(ptr_reg) + 3'h1;
  endproperty
  a_step_one: assert property (p_step_one) else $error("pointer did not step by one");

  property p_step_two;
    @(posedge clk) disable iff (reset) s_capture_two |=> ptr_reg == $past(ptr_reg) + 3'h2;
  endproperty
  a_step_two: assert property (p_step_two) else $error("pointer did not step by two");

  property p_wrap_sets;
    @(posedge clk) disable iff (reset) (capture && ptr_reg == 3'h7) |=> wrap_reg;
  endproperty
  a_wrap_sets: assert property (p_wrap_sets) else $error("wrap flag not set");

  property p_wrap_sticky;
    @(posedge clk) disable iff (reset) (wrap_reg && !wr_index) |=> wrap_reg;
  endproperty
  a_wrap_sticky: assert property (p_wrap_sticky) else $error("wrap flag dropped");

  property p_source_kind;
    @(posedge clk) disable iff (reset) capture |=> entry_reg[$past(ptr_reg)][KIND_BIT];
  endproperty
  a_source_kind: assert property (p_source_kind) else $error("source entry kind not set");

  property p_target_entry;
    @(posedge clk) disable iff (reset) s_capture_two |=>
      entry_reg[$past(ptr_plus1)][3:0] == 4'h2;
  endproperty
  a_target_entry: assert property (p_target_entry) else $error("target entry low bits wrong");

  property p_sext;
    @(posedge clk) disable iff (reset) capture |=>
      entry_reg[$past(ptr_reg)][SEXT_HI:SEXT_LO] == {10{entry_reg[$past(ptr_reg)][SEXT_SRC]}};
  endproperty
  a_sext: assert property (p_sext) else $error("captured address not sign extended");

  property p_reset_config;
    @(posedge clk) reset |=>
      !overflow_irq_enable && !external_visibility && interrupt_vector_suppress && collection_halted;
  endproperty
  a_reset_config: assert property (p_reset_config) else $error("control bits wrong after reset");

  property p_source_slot;
    @(posedge clk) disable iff (reset) capture |=> entry_reg[$past(ptr_reg)][SLOT_LO+1:SLOT_LO] ==
      ($past(branch_in.taken) ? $past(branch_in.slot) : SLOT_NOT_TAKEN);
  endproperty
  a_source_slot: assert property (p_source_slot) else $error("source slot field wrong");

  property p_source_addr;
    @(posedge clk) disable iff (reset) capture |=>
      entry_reg[$past(ptr_reg)][SEXT_LO-1:ADDR_LO] == $past(branch_in.src_addr[SEXT_LO-ADDR_LO-1:0]) &&
      entry_reg[$past(ptr_reg)][63:SEXT_HI+1] == $past(branch_in.src_addr[59:SEXT_HI+1-ADDR_LO]);
  endproperty
  a_source_addr: assert property (p_source_addr) else $error("source address field wrong");

  property p_mispredict;
    @(posedge clk) disable iff (reset) capture |=>
      entry_reg[$past(ptr_reg)][MISPRED_BIT] == $past(branch_in.mispredict);
  endproperty
  a_mispredict: assert property (p_mispredict) else $error("mispredict flag wrong");

  property p_index_load;
    @(posedge clk) disable iff (reset) (wr_index && w_strb_reg[0] && !capture) |=>
      {wrap_reg, ptr_reg} == $past({w_data_reg[WRAP_BIT], w_data_reg[PTR_W-1:0]});
  endproperty
  a_index_load: assert property (p_index_load) else $error("index write not loaded");

  property p_wrap_ptr;
    @(posedge clk) disable iff (reset) (capture && !two_entries && ptr_reg == 3'h7) |=> ptr_reg == 3'h0;
  endproperty
  a_wrap_ptr: assert property (p_wrap_ptr) else $error("pointer did not wrap to zero");

endmodule

// *** verilog/trace_pkg.sv ***
// Package: register map, entry layout and port carriers for the branch trace recorder
//
// Contract
// - Entry contents are only guaranteed while collection is halted.
// - Entry bit 0 is 1 for a branch source, 0 for a target.
// - Bit 1 with kind: mispredicted, correct, valid target or invalid entry.
// - Slot bits 3:2 are 00 for targets; slot index or 11 for sources.
// - Bits 63:4 hold the 60-bit source or target bundle address.
// - Captured bits 60:51 copy address bit 50; software writes store as written.
// - A qualified branch writes its source here and its target to the next entry.
// - A target that is itself a branch gives one source or two entries.
// - Jumps into legacy code record their target; legacy jumps to native record nothing.
// - Trapping or faulting branches may record the source without a target.
// - Eight circular entries; pointer post-increments on every recorded entry.
// - After eight entries the pointer wraps and overwrites the first entry.
// - Wrap flag bit 3 of index sets on each wrap and stays until cleared.
// - Writing the index register with byte 0 strobed loads both pointer and wrap flag; a capture in the same cycle steps the old pointer instead of loading it.
// - Pointer bits 2:0 name the next entry; oldest entry when wrapped.
// - Reset clears overflow-irq and visibility bits and sets the vector suppress bit.
// - Other monitor state, entries and index included, is undefined after reset.
// - Capture only while the legacy-mode flag is zero.
package trace_pkg;

  localparam int ENTRIES = 8;
  localparam int PTR_W   = 3;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ENTRY_LO_BASE = 8'h00;
  localparam logic [7:0] ENTRY_HI_BASE = 8'h04;
  localparam logic [7:0] INDEX_OFF     = 8'h40;
  localparam logic [7:0] CONFIG_OFF    = 8'h44;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int KIND_BIT     = 0;
  localparam int MISPRED_BIT  = 1;
  localparam int SLOT_LO      = 2;
  localparam int ADDR_LO      = 4;
  localparam int WRAP_BIT     = 3;
  localparam int SEXT_LO      = 51;
  localparam int SEXT_HI      = 60;
  localparam int SEXT_SRC     = 50;
  localparam int CFG_HALT_BIT = 0;
  localparam int CFG_OI_BIT   = 1;
  localparam int CFG_EV_BIT   = 2;
  localparam int CFG_SUPP_BIT = 3;

  localparam logic [1:0] SLOT_NOT_TAKEN = 2'h3;
  localparam logic [1:0] SLOT_TARGET    = 2'h0;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // Reset values of the control bits
  localparam logic CFG_HALT_RST = 1'b1;
  localparam logic CFG_OI_RST   = 1'b0;
  localparam logic CFG_EV_RST   = 1'b0;
  localparam logic CFG_SUPP_RST = 1'b1;

  typedef struct packed {
    logic        valid;
    logic [59:0] src_addr;
    logic [1:0]  slot;
    logic        taken;
    logic        mispredict;
    logic        record_target;
    logic        merge_source;
    logic [59:0] tgt_addr;
  } branch_event_t;

endpackage
